// [dv/board_pads.sv]
// Board side of the shared pads: drivers, pull-ups and floating lines
`timescale 1ns/1ps
`default_nettype none
module board_pads (
  // Clock
  input wire logic pclk,
  // Design pad controls
  input wire logic [13:0] pad_out,
  input wire logic [13:0] pad_oe,
  input wire logic [13:0] pad_pull,
  // Board drivers
  input wire logic [13:0] drv_en,
  input wire logic [13:0] drv_val,
  // Resolved pad levels
  output logic [13:0] pad_level
);
  logic [13:0] churn_q = 14'h0AAA;

  // Floating lines change every cycle
  always @(posedge pclk) begin
    churn_q <= ~churn_q;
  end

  always_comb begin
    for (int i = 0; i < 14; i++) begin
      if (pad_oe[i])
        pad_level[i] = pad_out[i];
      else if (drv_en[i])
        pad_level[i] = drv_val[i];
      else if (pad_pull[i])
        pad_level[i] = 1'b1;
      else
        pad_level[i] = churn_q[i];
    end
  end
endmodule
`default_nettype wire

// [dv/shared_pin_function_priority_mux_tb_top.sv]
// Self-checking bench of the shared pin priority multiplexer
`timescale 1ns/1ps
`default_nettype none
module shared_pin_function_priority_mux_tb_top;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] pull;
    logic [5:0] an;
    logic [1:0] tm;
    logic tc;
    logic [5:0] kp;
    logic [31:0] lo;
    logic [31:0] hi;
  } row_t;

  // ************************************************************
  // Owner table: requests beside expected owner words
  // ************************************************************
  localparam row_t rows [8] = '{
    '{8'h01, 8'h00, 6'h00, 2'h0, 1'b0, 6'h00, 32'h01010101, 32'h01010101},
    '{8'h01, 8'h00, 6'h00, 2'h0, 1'b0, 6'h3F, 32'h02020202, 32'h01010202},
    '{8'h01, 8'h00, 6'h00, 2'h3, 1'b0, 6'h3F, 32'h02020404, 32'h01010202},
    '{8'h01, 8'h00, 6'h3F, 2'h3, 1'b1, 6'h3F, 32'h02200808, 32'h08080808},
    '{8'h0B, 8'h00, 6'h00, 2'h0, 1'b1, 6'h3F, 32'h40100202, 32'h01010202},
    '{8'h11, 8'h00, 6'h3F, 2'h0, 1'b0, 6'h00, 32'h01010808, 32'h08088080},
    '{8'h21, 8'h00, 6'h00, 2'h0, 1'b0, 6'h3F, 32'h02020202, 32'h01018002},
    '{8'h01, 8'h80, 6'h00, 2'h0, 1'b0, 6'h00, 32'h01010101, 32'h01010180}
  };

  // ************************************************************
  // Signals
  // ************************************************************
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] pa_in, pa_out, pa_oe, pa_pull;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pull;
  logic [5:0] analog_input_en = 6'h00, keypad_en = 6'h00;
  logic [1:0] timer_channel_en = 2'h0, timer_channel_out = 2'h0;
  logic [1:0] timer_channel_oe = 2'h0, timer_channel_in;
  logic timer_clk_en = 1'b0, osc_clk_out = 1'b0;
  logic [5:0] analog_connect, keypad_wake_input;
  logic timer_external_clock_in, irq_level_n, reset_request;
  logic oscillator_input_pin;
  logic [13:0] drv_en = 14'h0000, drv_val = 14'h0000, pad_level;
  int mismatches = 0, check_count = 0;

  assign pa_in = pad_level[5:0];
  assign pb_in = pad_level[13:6];

  // Bus clock
  always #10 pclk = ~pclk;

  shared_pin_function_priority_mux uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe(pa_oe), .pa_pull(pa_pull), .pb_in(pb_in), .pb_out(pb_out),
    .pb_oe(pb_oe), .pb_pull(pb_pull), .analog_input_en(analog_input_en),
    .timer_channel_en(timer_channel_en),
    .timer_channel_out(timer_channel_out),
    .timer_channel_oe(timer_channel_oe), .timer_clk_en(timer_clk_en),
    .keypad_en(keypad_en), .osc_clk_out(osc_clk_out),
    .analog_connect(analog_connect), .timer_channel_in(timer_channel_in),
    .timer_external_clock_in(timer_external_clock_in),
    .keypad_wake_input(keypad_wake_input), .irq_level_n(irq_level_n),
    .reset_request(reset_request),
    .oscillator_input_pin(oscillator_input_pin)
  );

  board_pads board (
    .pclk(pclk), .pad_out({pb_out, pa_out}), .pad_oe({pb_oe, pa_oe}),
    .pad_pull({pb_pull, pa_pull}), .drv_en(drv_en), .drv_val(drv_val),
    .pad_level(pad_level)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, answer taken at the rising edge with pready high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic stop_test();
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(pinmux_pkg::OFS_CONFIG, 32'(pinmux_pkg::RST_CONFIG));
    rd_chk(pinmux_pkg::OFS_PA_PULL, 32'(pinmux_pkg::RST_PA_PULL));
    rd_chk(pinmux_pkg::OFS_PB_PULL, 32'(pinmux_pkg::RST_PB_PULL));
    rd_chk(pinmux_pkg::OFS_OWNER_LO, 32'h01010101);
    check(keypad_wake_input, 6'h3F);
    check(irq_level_n, 1'b1);
    wr(pinmux_pkg::OFS_PA_DATA, 32'h3F);
    wr(pinmux_pkg::OFS_PA_DIR, 32'h3F);
    wr(pinmux_pkg::OFS_PB_DIR, 32'hFC);
    wr(pinmux_pkg::OFS_PB_DATA, 32'hA5);
    settle();
    check(pa_oe, 6'h00);
    check(pb_oe, 8'h00);
    check(pb_out, 8'h00);
    foreach (rows[i]) begin
      wr(pinmux_pkg::OFS_CONFIG, 32'(rows[i].cfg));
      wr(pinmux_pkg::OFS_PA_PULL, 32'(rows[i].pull));
      analog_input_en <= rows[i].an;
      timer_channel_en <= rows[i].tm;
      timer_clk_en <= rows[i].tc;
      keypad_en <= rows[i].kp;
      settle();
      rd_chk(pinmux_pkg::OFS_OWNER_LO, rows[i].lo);
      rd_chk(pinmux_pkg::OFS_OWNER_HI, rows[i].hi);
    end
    // Port drive with timer and keypad on top
    wr(pinmux_pkg::OFS_CONFIG, 32'h01);
    wr(pinmux_pkg::OFS_PA_PULL, 32'h00);
    analog_input_en <= 6'h00;
    timer_clk_en <= 1'b0;
    timer_channel_en <= 2'h1;
    timer_channel_oe <= 2'h1;
    keypad_en <= 6'h02;
    settle();
    check(pa_oe, 6'h39);
    check(pa_out & 6'h38, 6'h38);
    check(pa_out[0], 1'b0);
    check(pb_oe, 8'hFC);
    check(pb_out, 8'hA5);
    @(posedge pclk);
    timer_channel_oe <= 2'h0;
    settle();
    check(pa_oe[0], 1'b0);
    rd_chk(pinmux_pkg::OFS_PA_DIR, 32'h3F);
    analog_input_en <= 6'h01;
    timer_channel_oe <= 2'h1;
    timer_channel_out <= 2'h1;
    settle();
    check({pa_oe[0], pa_out[0], analog_connect[0]}, 3'b111);
    // port kept as input under keypad use
    wr(pinmux_pkg::OFS_PA_DIR, 32'h00);
    analog_input_en <= 6'h00;
    timer_channel_en <= 2'h0;
    timer_channel_oe <= 2'h0;
    keypad_en <= 6'h3F;
    drv_en <= 14'h003F;
    drv_val <= 14'h003D;
    settle();
    check(keypad_wake_input, 6'h3D);
    rd_chk(pinmux_pkg::OFS_PA_LEVEL, 32'h3D);
    keypad_en <= 6'h00;
    timer_channel_en <= 2'h3;
    timer_clk_en <= 1'b1;
    settle();
    check(timer_channel_in, 2'b01);
    check(timer_external_clock_in, 1'b1);
    @(posedge pclk);
    timer_channel_en <= 2'h0;
    drv_val <= 14'h0031;
    wr(pinmux_pkg::OFS_CONFIG, 32'h07);
    settle();
    check(irq_level_n, 1'b0);
    check(pa_pull, 6'h04);
    wr(pinmux_pkg::OFS_CONFIG, 32'h0F);
    settle();
    check(reset_request, 1'b1);
    check(pa_pull, 6'h0C);
    wr(pinmux_pkg::OFS_CONFIG, 32'h2F);
    settle();
    check(oscillator_input_pin, 1'b1);
    @(posedge pclk);
    drv_en <= 14'h002F;
    osc_clk_out <= 1'b1;
    wr(pinmux_pkg::OFS_CONFIG, 32'h11);
    settle();
    check({pa_oe[4], pa_out[4]}, 2'b11);
    @(posedge pclk);
    osc_clk_out <= 1'b0;
    settle();
    check(pa_out[4], 1'b0);
    wr(pinmux_pkg::OFS_CONFIG, 32'h01);
    wr(pinmux_pkg::OFS_PA_PULL, 32'h80);
    settle();
    check(pa_oe[4], 1'b1);
    wr(pinmux_pkg::OFS_PB_DIR, 32'h00);
    wr(pinmux_pkg::OFS_PB_PULL, 32'hFD);
    wr(pinmux_pkg::OFS_PA_PULL, 32'h15);
    settle();
    check(pa_pull, 6'h15);
    check(pb_pull, 8'hFD);
    // Unmapped address is refused
    apb(1'b0, 8'h2C, 32'h0);
    check(rd, 32'h0);
    check(err, 1'b1);
    // Second reset in mid-run
    drv_en <= 14'h0000;
    wr(pinmux_pkg::OFS_PA_DIR, 32'h3F);
    settle();
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check(pa_oe, 6'h00);
    @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(pinmux_pkg::OFS_CONFIG, 32'(pinmux_pkg::RST_CONFIG));
    stop_test();
  end
endmodule
`default_nettype wire

// [rtl/pin_owner_cell.sv]
// One pad: picks the owning function and the driving function
`timescale 1ns/1ps
`default_nettype none
module pin_owner_cell #(
  parameter bit INPUT_ONLY = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Candidate functions, slot 3 highest
  input wire logic armed,
  input wire logic [3:0] req,
  input wire logic [3:0][7:0] slot_code,
  input wire logic [3:0] slot_passive,
  input wire logic [3:0] slot_oe,
  input wire logic [3:0] slot_out,
  input wire logic [3:0] slot_pull,
  // Port settings
  input wire logic port_dir,
  input wire logic port_data,
  input wire logic port_pull,
  // Pad and decision
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pull,
  output logic [7:0] owner,
  output logic [3:0] drv_slot
);

  logic out_d, oe_d, pull_d, own_found, drv_found;
  logic [7:0] owner_d;
  logic [3:0] drv_d;

  // Priority walk from the top slot down
  always_comb begin
    owner_d = pinmux_pkg::OWN_PORT;
    drv_d = 4'h0;
    oe_d = port_dir;
    out_d = port_data;
    pull_d = port_pull;
    own_found = 1'b0;
    drv_found = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (req[i] && !own_found) begin
        owner_d = slot_code[i];
        own_found = 1'b1;
      end
      if (req[i] && !slot_passive[i] && !drv_found) begin
        drv_d = 4'(1 << i);
        oe_d = slot_oe[i];
        out_d = slot_out[i];
        pull_d = port_pull | slot_pull[i];
        drv_found = 1'b1;
      end
    end
    if (!armed) begin
      owner_d = pinmux_pkg::OWN_PORT;
      drv_d = 4'h0;
      oe_d = 1'b0;
      out_d = 1'b0;
      pull_d = port_pull;
    end
    if (INPUT_ONLY) begin
      oe_d = 1'b0;
    end
  end

  // Registered pad controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pad_pull <= 1'b0;
      owner <= pinmux_pkg::OWN_PORT;
      drv_slot <= 4'h0;
    end else begin
      pad_out <= out_d;
      pad_oe <= oe_d;
      pad_pull <= pull_d && !oe_d; // Pull-up only while not driving
      owner <= owner_d;
      drv_slot <= drv_d;
    end
  end

endmodule
`default_nettype wire

// [rtl/pinmux_pkg.sv]
// Constants, owner codes and register map of the shared pin multiplexer
//
// Notes on behaviour
// - Port A bit 0 order: analog 0, timer channel 0, keypad 0, port.
// - Port A bit 1 order: analog 1, timer channel 1, keypad 1, port.
// - Port A bit 2 order: external interrupt, timer clock, keypad 2, port.
// - Port A bit 3 order: reset input, keypad 3, port.
// - Port A bit 4 order: oscillator output, analog 2, keypad 4, port.
// - Port A bit 5 order: oscillator input, analog 3, keypad 5, port.
// - Port B bit 0: analog 4 wins over the port.
// - Port B bit 1: analog 5 wins over the port.
// - After reset every shared pin is a port input whatever is requested.
// - Analog selection never blocks the other functions sharing the pin.
// - Port A bit 4 drives crystal or clock output when enabled.
// - Port A bit 5 feeds the oscillator input when that function owns it.
// - Port A bit 2 is never driven as an output.
// - Reset function treats low as reset request and forces the pull-up.
// - Every pin has its own software pull-up enable.
// - External interrupt input has a software switchable pull-up.
package pinmux_pkg;

  // ************************************************************
  // Pin owners, one-hot
  // ************************************************************
  typedef enum logic [7:0] {
    OWN_PORT   = 8'h01,
    OWN_KEY    = 8'h02,
    OWN_TIMER  = 8'h04,
    OWN_ANALOG = 8'h08,
    OWN_IRQ    = 8'h10,
    OWN_TIMER_EXTERNAL_CLOCK_IN   = 8'h20,
    OWN_RESET  = 8'h40,
    OWN_OSC    = 8'h80
  } owner_t;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int PA_W = 6;
  localparam int PB_W = 8;
  localparam int PIN_N = 14;
  localparam int SLOT_N = 4;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_PA_DATA = 8'h00;
  localparam logic [7:0] OFS_PA_DIR = 8'h04;
  localparam logic [7:0] OFS_PA_PULL = 8'h08;
  localparam logic [7:0] OFS_PB_DATA = 8'h0C;
  localparam logic [7:0] OFS_PB_DIR = 8'h10;
  localparam logic [7:0] OFS_PB_PULL = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;
  localparam logic [7:0] OFS_PA_LEVEL = 8'h1C;
  localparam logic [7:0] OFS_PB_LEVEL = 8'h20;
  localparam logic [7:0] OFS_OWNER_LO = 8'h24;
  localparam logic [7:0] OFS_OWNER_HI = 8'h28;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CLK_OUT_EN_BIT = 7;   // In the port A pull-up register
  localparam int CFG_ARM_BIT = 0;
  localparam int CFG_IRQ_EN_BIT = 1;
  localparam int CFG_IRQ_PULL_BIT = 2;
  localparam int CFG_RESET_EN_BIT = 3;
  localparam int CFG_XTAL_BIT = 4;
  localparam int CFG_OSC_IN_BIT = 5;
  localparam int CFG_W = 6;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_PA_PULL = 8'h00;
  localparam logic [7:0] RST_PB_PULL = 8'h00;
  localparam logic [5:0] RST_CONFIG = 6'h00;

endpackage

// [rtl/shared_pin_function_priority_mux.sv]
// Shared pin priority multiplexer with its APB register file
`timescale 1ns/1ps
`default_nettype none
module shared_pin_function_priority_mux (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire logic [5:0] pa_in,
  output logic [5:0] pa_out,
  output logic [5:0] pa_oe,
  output logic [5:0] pa_pull,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pull,
  // Peripheral requests
  input wire logic [5:0] analog_input_en,
  input wire logic [1:0] timer_channel_en,
  input wire logic [1:0] timer_channel_out,
  input wire logic [1:0] timer_channel_oe,
  input wire logic timer_clk_en,
  input wire logic [5:0] keypad_en,
  input wire logic osc_clk_out,
  // Peripheral inputs
  output logic [5:0] analog_connect,
  output logic [1:0] timer_channel_in,
  output logic timer_external_clock_in,
  output logic [5:0] keypad_wake_input,
  output logic irq_level_n,
  output logic reset_request,
  output logic oscillator_input_pin
);

  // ************************************************************
  // Register file
  // ************************************************************
  logic [5:0] pa_data_q, pa_dir_q;
  logic [7:0] pa_pull_q;
  logic [7:0] pb_data_q, pb_dir_q, pb_pull_q;
  logic [5:0] cfg_q;
  logic setup, wr;
  logic armed, clock_out_enable;

  // Address decode shared by write and error paths
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      pinmux_pkg::OFS_PA_DATA, pinmux_pkg::OFS_PA_DIR,
      pinmux_pkg::OFS_PA_PULL, pinmux_pkg::OFS_PB_DATA,
      pinmux_pkg::OFS_PB_DIR, pinmux_pkg::OFS_PB_PULL,
      pinmux_pkg::OFS_CONFIG, pinmux_pkg::OFS_PA_LEVEL,
      pinmux_pkg::OFS_PB_LEVEL, pinmux_pkg::OFS_OWNER_LO,
      pinmux_pkg::OFS_OWNER_HI: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  logic [7:0] owner_w [14];
  logic [31:0] rd_d;

  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && reg_hit(paddr);
  assign armed = cfg_q[pinmux_pkg::CFG_ARM_BIT];
  assign clock_out_enable = pa_pull_q[pinmux_pkg::CLK_OUT_EN_BIT];

  // Read data mux
  always_comb begin
    case (paddr)
      pinmux_pkg::OFS_PA_DATA: rd_d = {26'h0, pa_data_q};
      pinmux_pkg::OFS_PA_DIR: rd_d = {26'h0, pa_dir_q};
      pinmux_pkg::OFS_PA_PULL: rd_d = {24'h0, pa_pull_q};
      pinmux_pkg::OFS_PB_DATA: rd_d = {24'h0, pb_data_q};
      pinmux_pkg::OFS_PB_DIR: rd_d = {24'h0, pb_dir_q};
      pinmux_pkg::OFS_PB_PULL: rd_d = {24'h0, pb_pull_q};
      pinmux_pkg::OFS_CONFIG: rd_d = {26'h0, cfg_q};
      pinmux_pkg::OFS_PA_LEVEL: rd_d = {26'h0, pa_in};
      pinmux_pkg::OFS_PB_LEVEL: rd_d = {24'h0, pb_in};
      pinmux_pkg::OFS_OWNER_LO:
        rd_d = {owner_w[3], owner_w[2], owner_w[1], owner_w[0]};
      pinmux_pkg::OFS_OWNER_HI:
        rd_d = {owner_w[7], owner_w[6], owner_w[5], owner_w[4]};
      default: rd_d = 32'h0;
    endcase
  end

  // APB answer, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !reg_hit(paddr);
      prdata <= (setup && !pwrite) ? rd_d : 32'h0;
    end
  end

  // Port A settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_data_q <= 6'h00;
      pa_dir_q <= 6'h00;
      pa_pull_q <= pinmux_pkg::RST_PA_PULL;
    end else if (wr) begin
      if (paddr == pinmux_pkg::OFS_PA_DATA) pa_data_q <= pwdata[5:0];
      if (paddr == pinmux_pkg::OFS_PA_DIR) pa_dir_q <= pwdata[5:0];
      if (paddr == pinmux_pkg::OFS_PA_PULL) pa_pull_q <= pwdata[7:0];
    end
  end

  // Port B settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_data_q <= 8'h00;
      pb_dir_q <= 8'h00;
      pb_pull_q <= pinmux_pkg::RST_PB_PULL;
    end else if (wr) begin
      if (paddr == pinmux_pkg::OFS_PB_DATA) pb_data_q <= pwdata[7:0];
      if (paddr == pinmux_pkg::OFS_PB_DIR) pb_dir_q <= pwdata[7:0];
      if (paddr == pinmux_pkg::OFS_PB_PULL) pb_pull_q <= pwdata[7:0];
    end
  end

  // Function configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= pinmux_pkg::RST_CONFIG;
    end else if (wr && paddr == pinmux_pkg::OFS_CONFIG) begin
      cfg_q <= pwdata[5:0];
    end
  end

  // ************************************************************
  // Candidate table per pin
  // ************************************************************
  logic [3:0] req [14];
  logic [3:0][7:0] code [14];
  logic [3:0] pas [14], s_oe [14], s_out [14], s_pull [14];
  logic [13:0] p_dir, p_data, p_pull, pad_out_w, pad_oe_w, pad_pull_w;
  logic [3:0] drv_w [14];
  logic osc_out_on, osc_in_on;

  assign osc_out_on = cfg_q[pinmux_pkg::CFG_XTAL_BIT] || clock_out_enable;
  assign osc_in_on = cfg_q[pinmux_pkg::CFG_OSC_IN_BIT] ||
                     cfg_q[pinmux_pkg::CFG_XTAL_BIT];
  assign p_dir = {pb_dir_q, pa_dir_q};
  assign p_data = {pb_data_q, pa_data_q};
  assign p_pull = {pb_pull_q, pa_pull_q[5:0]};

  always_comb begin
    for (int p = 0; p < 14; p++) begin
      req[p] = 4'h0;
      code[p] = '0;
      pas[p] = 4'h0;
      s_oe[p] = 4'h0;
      s_out[p] = 4'h0;
      s_pull[p] = 4'h0;
    end
    for (int p = 0; p < 2; p++) begin
      req[p] = {analog_input_en[p], timer_channel_en[p], keypad_en[p], 1'b0};
      code[p] = {pinmux_pkg::OWN_ANALOG, pinmux_pkg::OWN_TIMER,
                 pinmux_pkg::OWN_KEY, pinmux_pkg::OWN_PORT};
      pas[p] = 4'h8;
      s_oe[p][2] = timer_channel_oe[p];
      s_out[p][2] = timer_channel_out[p];
    end
    req[2] = {cfg_q[pinmux_pkg::CFG_IRQ_EN_BIT], timer_clk_en,
              keypad_en[2], 1'b0};
    code[2] = {pinmux_pkg::OWN_IRQ, pinmux_pkg::OWN_TIMER_EXTERNAL_CLOCK_IN,
               pinmux_pkg::OWN_KEY, pinmux_pkg::OWN_PORT};
    s_pull[2][3] = cfg_q[pinmux_pkg::CFG_IRQ_PULL_BIT];
    req[3] = {cfg_q[pinmux_pkg::CFG_RESET_EN_BIT], keypad_en[3], 2'b00};
    code[3] = {pinmux_pkg::OWN_RESET, pinmux_pkg::OWN_KEY,
               pinmux_pkg::OWN_PORT, pinmux_pkg::OWN_PORT};
    s_pull[3][3] = 1'b1;
    for (int p = 4; p < 6; p++) begin
      req[p] = {(p == 4) ? osc_out_on : osc_in_on, analog_input_en[p - 2],
                keypad_en[p], 1'b0};
      code[p] = {pinmux_pkg::OWN_OSC, pinmux_pkg::OWN_ANALOG,
                 pinmux_pkg::OWN_KEY, pinmux_pkg::OWN_PORT};
      pas[p] = 4'h4;
    end
    s_oe[4][3] = 1'b1;
    s_out[4][3] = osc_clk_out;
    for (int p = 6; p < 8; p++) begin
      req[p] = {analog_input_en[p - 2], 3'b000};
      code[p] = {pinmux_pkg::OWN_ANALOG, pinmux_pkg::OWN_PORT,
                 pinmux_pkg::OWN_PORT, pinmux_pkg::OWN_PORT};
      pas[p] = 4'h8;
    end
  end

  // One decision cell per pad
  for (genvar g = 0; g < 14; g++) begin : g_pin
    pin_owner_cell #(.INPUT_ONLY(g == 2)) u_cell (
      .pclk(pclk),
      .presetn(presetn),
      .armed(armed),
      .req(req[g]),
      .slot_code(code[g]),
      .slot_passive(pas[g]),
      .slot_oe(s_oe[g]),
      .slot_out(s_out[g]),
      .slot_pull(s_pull[g]),
      .port_dir(p_dir[g]),
      .port_data(p_data[g]),
      .port_pull(p_pull[g]),
      .pad_out(pad_out_w[g]),
      .pad_oe(pad_oe_w[g]),
      .pad_pull(pad_pull_w[g]),
      .owner(owner_w[g]),
      .drv_slot(drv_w[g])
    );
  end

  assign pa_out = pad_out_w[5:0];
  assign pa_oe = pad_oe_w[5:0];
  assign pa_pull = pad_pull_w[5:0];
  assign pb_out = pad_out_w[13:6];
  assign pb_oe = pad_oe_w[13:6];
  assign pb_pull = pad_pull_w[13:6];

  // ************************************************************
  // Pad levels to peripherals
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_connect <= 6'h00;
      timer_channel_in <= 2'b00;
      timer_external_clock_in <= 1'b0;
      keypad_wake_input <= 6'h3F;
      irq_level_n <= 1'b1;
      reset_request <= 1'b0;
      oscillator_input_pin <= 1'b0;
    end else begin
      for (int k = 0; k < 6; k++) begin
        analog_connect[k] <= owner_w[(k < 2) ? k : k + 2] ==
                             pinmux_pkg::OWN_ANALOG;
        keypad_wake_input[k] <= drv_w[k][1] ? pa_in[k] : 1'b1;
      end
      keypad_wake_input[3] <= drv_w[3][2] ? pa_in[3] : 1'b1;
      timer_channel_in <= {drv_w[1][2] & pa_in[1], drv_w[0][2] & pa_in[0]};
      timer_external_clock_in <= drv_w[2][2] & pa_in[2];
      irq_level_n <= drv_w[2][3] ? pa_in[2] : 1'b1;
      reset_request <= drv_w[3][3] && !pa_in[3];
      oscillator_input_pin <= drv_w[5][3] & pa_in[5];
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_input_only;
    armed |=> pa_oe[2] == 1'b0;
  endproperty
  a_input_only: assert property (p_input_only)
    else $error("Port A bit 2 driven");

  property p_reset_inputs;
    (!armed)[*2] |-> pa_oe == 6'h00 && pb_oe == 8'h00;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs)
    else $error("Pin driven while unarmed");

  property p_a0_order;
    armed && analog_input_en[0] |=> owner_w[0] == pinmux_pkg::OWN_ANALOG;
  endproperty
  a_a0_order: assert property (p_a0_order)
    else $error("Analog 0 lost port A bit 0");

  property p_a1_order;
    armed && !analog_input_en[1] && timer_channel_en[1]
      |=> owner_w[1] == pinmux_pkg::OWN_TIMER;
  endproperty
  a_a1_order: assert property (p_a1_order)
    else $error("Timer 1 lost port A bit 1");

  property p_a2_order;
    armed && cfg_q[pinmux_pkg::CFG_IRQ_EN_BIT] && timer_clk_en
      |=> owner_w[2] == pinmux_pkg::OWN_IRQ;
  endproperty
  a_a2_order: assert property (p_a2_order)
    else $error("Interrupt lost port A bit 2");

  property p_a3_reset;
    armed && cfg_q[pinmux_pkg::CFG_RESET_EN_BIT]
      |=> owner_w[3] == pinmux_pkg::OWN_RESET && pa_pull[3] && !pa_oe[3];
  endproperty
  a_a3_reset: assert property (p_a3_reset)
    else $error("Reset function not owning bit 3 with pull-up");

  property p_clock_out;
    armed && clock_out_enable
      |=> pa_oe[4] && pa_out[4] == $past(osc_clk_out);
  endproperty
  a_clock_out: assert property (p_clock_out)
    else $error("Clock not on port A bit 4");

  property p_osc_in;
    (armed && osc_in_on)[*2] |=> oscillator_input_pin == $past(pa_in[5]);
  endproperty
  a_osc_in: assert property (p_osc_in)
    else $error("Oscillator input not fed from bit 5");

  property p_b_analog;
    armed && analog_input_en[4]
      |=> owner_w[6] == pinmux_pkg::OWN_ANALOG ##1 analog_connect[4];
  endproperty
  a_b_analog: assert property (p_b_analog)
    else $error("Analog 4 lost port B bit 0");

  property p_timer_drive;
    armed && timer_channel_en[0] && !keypad_en[0]
      |=> pa_oe[0] == $past(timer_channel_oe[0]);
  endproperty
  a_timer_drive: assert property (p_timer_drive)
    else $error("Port setting leaked past timer 0");

  property p_pull_b7;
    !pb_dir_q[7] |=> pb_pull[7] == $past(pb_pull_q[7]);
  endproperty
  a_pull_b7: assert property (p_pull_b7)
    else $error("Pull-up of port B bit 7 wrong");

  c_analog_share: cover property (armed && analog_input_en[0]
                                  && timer_channel_en[0]);
  c_reset_pin: cover property (reset_request);
  c_clock_out: cover property (armed && clock_out_enable ##1 pa_oe[4]);
  c_apb_error: cover property (pready && pslverr);

endmodule
`default_nettype wire
